// ---- core/trace_pkg.sv ----
// Function
// - Trigger level arrives as two 16-bit words, high word first, assembled in order.
// - Type 1 fires on first sample with channel value at or above level.
// - Type 2 fires on first sample with channel value at or below level.
// - Type 3 fires when channel value crosses the level upward.
// - Type 4 fires when channel value crosses the level downward.
// - Type 5 fires when any level-masked channel bit is one.
// - Type 6 fires when any level-masked channel bit is zero.
// - Type 7 fires whenever channel value differs from previous sample.
// - Type 8 fires on a masked event status bit rising; channel ignored.
// - Type 9 fires on a masked event status bit falling; channel ignored.
// - Type 10 fires at next function generator cycle start, only while active.
// - Type 11 fires on masked capture status bit set, then clears those bits.
// - Signed 16-bit delay in trace periods between trigger and first sample; single mode (config word bit 15) ignores it.
// - Negative delay delivers data starting that many periods before the trigger, except in single mode (config word bit 15).
// - Any delay accepted; pre-trigger samples clamped to one less than buffer capacity.
// - Writing zero to run control stops collection; non-zero restarts it.
// - Completed trace reads out sequentially as 32-bit samples.
// - Config word: channel in bits 0-3, type in bits 8-11.
// - Sample interval is trace period times the reference period.
// - Read-only 16-bit count of samples collected in the current trace.
package trace_pkg;

  // ---------------------------------------------------------------
  // Object indices and subindices
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_SAMPLE_COUNT = 16'h2503;
  localparam logic [15:0] IDX_MAX_SAMPLES = 16'h2504;
  localparam logic [15:0] IDX_PERIOD = 16'h2505;
  localparam logic [15:0] IDX_TRIG_CFG = 16'h2506;
  localparam logic [15:0] IDX_DELAY = 16'h2507;
  localparam logic [15:0] IDX_RUN = 16'h2508;
  localparam logic [15:0] IDX_DATA = 16'h2509;
  localparam logic [7:0] SUB_CFG = 8'h00;
  localparam logic [7:0] SUB_LVL_HI = 8'h01;
  localparam logic [7:0] SUB_LVL_LO = 8'h02;

  // ---------------------------------------------------------------
  // Field layout of the first trigger configuration word
  // ---------------------------------------------------------------
  localparam int CH_LSB = 0;
  localparam int CH_W = 4;
  localparam int TYPE_LSB = 8;
  localparam int TYPE_W = 4;
  localparam int SINGLE_BIT = 15;

  // ---------------------------------------------------------------
  // Buffer geometry and reset values
  // ---------------------------------------------------------------
  localparam int BUF_AW = 13;
  localparam logic [15:0] BUF_DEPTH = 16'h2000;
  localparam logic [BUF_AW-1:0] MAX_PRE = 13'h1FFF;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h0001;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] RUN_RST = 16'h0000;

  typedef enum logic [3:0] {
    TRG_NONE = 4'h0, TRG_GE = 4'h1, TRG_LE = 4'h2, TRG_RISE = 4'h3,
    TRG_FALL = 4'h4, TRG_SET = 4'h5, TRG_CLR = 4'h6, TRG_CHANGE = 4'h7,
    TRG_EV_RISE = 4'h8, TRG_EV_FALL = 4'h9, TRG_FGEN = 4'hA, TRG_CAPT = 4'hB
  } trig_type_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_COLLECT = 2'b11,
    ST_DONE = 2'b10
  } cap_state_t;

  function automatic logic obj_hit(input logic [15:0] idx, input logic [7:0] sub,
                                   input logic [15:0] want_idx, input logic [7:0] want_sub);
    obj_hit = (idx == want_idx) && (sub == want_sub);
  endfunction : obj_hit

endpackage : trace_pkg

// ---- core/stream_if.sv ----
`timescale 1ns/1ps
interface stream_if;
  logic valid;
  logic ready;
  logic [31:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : stream_if

// ---- core/pair_buffer.sv ----
`timescale 1ns/1ps
module pair_buffer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  stream_if.snk in_s,
  stream_if.src out_s
);
  import trace_pkg::*;

  logic [31:0] slot_q [2];
  logic wr_sel_q;
  logic rd_sel_q;
  logic [1:0] fill_q;
  wire push = in_s.valid && in_s.ready;
  wire pop = out_s.valid && out_s.ready;

  assign in_s.ready = (fill_q != 2'h2);
  assign out_s.valid = (fill_q != 2'h0);
  assign out_s.data = slot_q[rd_sel_q];

  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      slot_q[wr_sel_q] <= in_s.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_sel_q <= 1'b0;
      rd_sel_q <= 1'b0;
      fill_q <= 2'd0;
    end else if (clk_en) begin
      if (push) wr_sel_q <= ~wr_sel_q;
      if (pop) rd_sel_q <= ~rd_sel_q;
      fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : pair_buffer

// ---- core/trigger_detect.sv ----
`timescale 1ns/1ps
module trigger_detect (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic arm,
  input wire logic sample_en,
  input wire logic [3:0] trig_type,
  input wire logic [31:0] level,
  input wire logic [31:0] chan_val,
  input wire logic [31:0] event_status,
  input wire logic [31:0] capture_status,
  input wire logic fgen_start,
  input wire logic fgen_active,
  output logic fire
);
  import trace_pkg::*;

  logic [31:0] prev_chan_q;
  logic [31:0] prev_event_q;
  logic prev_ok_q;
  logic fgen_seen_q;

  wire signed [31:0] cur_s = chan_val;
  wire signed [31:0] prev_s = prev_chan_q;
  wire signed [31:0] lvl_s = level;
  wire ge = cur_s >= lvl_s;
  wire le = cur_s <= lvl_s;
  wire rise = prev_ok_q && (prev_s < lvl_s) && ge;
  wire fall = prev_ok_q && (prev_s > lvl_s) && le;
  wire any_set = |(chan_val & level);
  wire any_clr = |(~chan_val & level);
  wire changed = prev_ok_q && (chan_val != prev_chan_q);
  wire ev_rise = prev_ok_q && |(event_status & ~prev_event_q & level);
  wire ev_fall = prev_ok_q && |(~event_status & prev_event_q & level);
  wire fgen_hit = fgen_seen_q || (fgen_start && fgen_active);
  wire capt_hit = |(capture_status & level);

  logic cond;
  always_comb begin
    case (trig_type)
      TRG_NONE: cond = 1'b1;
      TRG_GE: cond = ge;
      TRG_LE: cond = le;
      TRG_RISE: cond = rise;
      TRG_FALL: cond = fall;
      TRG_SET: cond = any_set;
      TRG_CLR: cond = any_clr;
      TRG_CHANGE: cond = changed;
      TRG_EV_RISE: cond = ev_rise;
      TRG_EV_FALL: cond = ev_fall;
      TRG_FGEN: cond = fgen_hit;
      TRG_CAPT: cond = capt_hit;
      default: cond = 1'b0;
    endcase
  end

  assign fire = sample_en && cond;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_chan_q <= 32'h0000_0000;
      prev_event_q <= 32'h0000_0000;
      prev_ok_q <= 1'b0;
      fgen_seen_q <= 1'b0;
    end else if (clk_en) begin
      if (arm) begin
        prev_ok_q <= 1'b0;
        fgen_seen_q <= 1'b0;
      end else begin
        if (sample_en) begin
          prev_chan_q <= chan_val;
          prev_event_q <= event_status;
          prev_ok_q <= 1'b1;
        end
        // A generator start between samples is held so it is not missed; a new start wins over consumption.
        if (fgen_start && fgen_active) fgen_seen_q <= 1'b1;
        else if (sample_en) fgen_seen_q <= 1'b0;
      end
    end
  end
endmodule : trigger_detect

// ---- core/trace_capture.sv ----
`timescale 1ns/1ps
module trace_capture (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic obj_req,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  input wire logic [31:0] obj_wdata,
  input wire logic rsp_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  output logic rsp_err,
  input wire logic ref_tick,
  input wire logic [31:0] sample_word,
  input wire logic [31:0] trig_chan_value,
  input wire logic [31:0] event_status,
  input wire logic [31:0] capture_status,
  input wire logic fgen_start,
  input wire logic fgen_active,
  output logic [3:0] trig_chan,
  output logic [31:0] capture_clr,
  output logic trace_busy,
  output logic trace_done
);
  import trace_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] cfg_q;
  logic [15:0] lvl_hi_q;
  logic [31:0] level_q;
  logic [15:0] period_q;
  logic [15:0] delay_q;
  logic [15:0] run_q;
  cap_state_t state_q;
  logic [15:0] per_cnt_q;
  logic [BUF_AW-1:0] wr_ptr_q;
  logic [BUF_AW-1:0] start_q;
  logic [BUF_AW-1:0] pre_have_q;
  logic [15:0] count_q;
  logic [15:0] post_wait_q;
  logic [BUF_AW-1:0] rd_ptr_q;
  logic [15:0] rd_left_q;
  logic pend_q;
  logic [31:0] mem_q;
  logic [31:0] buf_mem [BUF_DEPTH];
  logic rsp_valid_q;
  logic [31:0] rsp_data_q;
  logic rsp_err_q;
  logic [31:0] capture_clr_q;

  stream_if rd_in ();
  stream_if rd_out ();

  // ---------------------------------------------------------------
  // Object access decode
  // ---------------------------------------------------------------
  wire accept = obj_req && !rsp_valid_q;
  wire acc_wr = accept && obj_wr;
  wire acc_rd = accept && !obj_wr;
  wire hit_count = obj_hit(obj_index, obj_sub, IDX_SAMPLE_COUNT, 8'h00);
  wire hit_max = obj_hit(obj_index, obj_sub, IDX_MAX_SAMPLES, 8'h00);
  wire hit_period = obj_hit(obj_index, obj_sub, IDX_PERIOD, 8'h00);
  wire hit_cfg = obj_hit(obj_index, obj_sub, IDX_TRIG_CFG, SUB_CFG);
  wire hit_lhi = obj_hit(obj_index, obj_sub, IDX_TRIG_CFG, SUB_LVL_HI);
  wire hit_llo = obj_hit(obj_index, obj_sub, IDX_TRIG_CFG, SUB_LVL_LO);
  wire hit_delay = obj_hit(obj_index, obj_sub, IDX_DELAY, 8'h00);
  wire hit_run = obj_hit(obj_index, obj_sub, IDX_RUN, 8'h00);
  wire hit_data = (obj_index == IDX_DATA);
  wire hit_rw = hit_period || hit_cfg || hit_lhi || hit_llo || hit_delay || hit_run;
  wire [15:0] wr16 = obj_wdata[15:0];
  wire wr_run = acc_wr && hit_run;
  wire restart = wr_run && (wr16 != 16'h0000);
  wire stop = wr_run && (wr16 == 16'h0000);
  wire data_ok = rd_out.valid;
  wire wr_err = !hit_rw;
  wire rd_err = hit_data ? !data_ok : !(hit_rw || hit_count || hit_max);

  wire [31:0] rd_mux =
    hit_count ? {16'h0000, count_q} :
    hit_max ? {16'h0000, BUF_DEPTH} :
    hit_period ? {16'h0000, period_q} :
    hit_cfg ? {16'h0000, cfg_q} :
    hit_lhi ? {16'h0000, level_q[31:16]} :
    hit_llo ? {16'h0000, level_q[15:0]} :
    hit_delay ? {16'h0000, delay_q} :
    hit_run ? {16'h0000, run_q} :
    hit_data ? rd_out.data : 32'h0000_0000;

  // Outside the done state stale readout words are drained.
  assign rd_out.ready = (acc_rd && hit_data) || (state_q != ST_DONE);

  // ---------------------------------------------------------------
  // Configuration fields and sample timing
  // ---------------------------------------------------------------
  wire [3:0] trig_type = cfg_q[TYPE_LSB +: TYPE_W];
  wire single_mode = cfg_q[SINGLE_BIT];
  wire [15:0] eff_period = (period_q == 16'h0000) ? 16'h0001 : period_q;
  wire [15:0] per_next = per_cnt_q + 16'h0001;
  wire sample_en = ref_tick && (per_next >= eff_period);

  // ---------------------------------------------------------------
  // Pre-trigger depth, clamped to what the ring can hold
  // ---------------------------------------------------------------
  wire delay_neg = delay_q[15];
  wire [15:0] delay_mag = 16'h0000 - delay_q;
  wire [BUF_AW-1:0] pre_lim = !delay_neg ? '0 :
                              (delay_mag > {3'b000, MAX_PRE}) ? MAX_PRE : delay_mag[BUF_AW-1:0];

  logic fire_raw;
  trigger_detect u_trig (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .arm(restart),
    .sample_en(sample_en),
    .trig_type(trig_type),
    .level(level_q),
    .chan_val(trig_chan_value),
    .event_status(event_status),
    .capture_status(capture_status),
    .fgen_start(fgen_start),
    .fgen_active(fgen_active),
    .fire(fire_raw)
  );

  wire armed = (state_q == ST_ARMED);
  wire fire = armed && fire_raw && !restart && !stop;
  wire collecting = (state_q == ST_COLLECT) && !restart && !stop;
  wire buf_full_next = (count_q + 16'h0001) == BUF_DEPTH;

  // Continuous ring writes only while a negative delay needs history.
  wire pre_wr = armed && sample_en && !single_mode && (pre_lim != '0) && !restart && !stop;
  wire fire_wr = fire && (single_mode || delay_neg || (delay_q == 16'h0000));
  wire coll_wr = collecting && sample_en && (post_wait_q == 16'h0000);
  wire mem_wr = pre_wr || fire_wr || coll_wr;
  wire [BUF_AW-1:0] wr_ptr_inc = wr_ptr_q + 1'b1;

  // ---------------------------------------------------------------
  // Buffer memory
  // ---------------------------------------------------------------
  wire rd_issue = (rd_left_q != 16'h0000) && (!pend_q || rd_in.ready);
  assign rd_in.valid = pend_q;
  assign rd_in.data = mem_q;

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (mem_wr) buf_mem[wr_ptr_q] <= sample_word;
      if (rd_issue) mem_q <= buf_mem[rd_ptr_q];
    end
  end

  pair_buffer u_rdbuf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_s(rd_in),
    .out_s(rd_out)
  );

  // ---------------------------------------------------------------
  // Writable objects
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RST;
      lvl_hi_q <= 16'h0000;
      level_q <= 32'h0000_0000;
      period_q <= PERIOD_RST;
      delay_q <= DELAY_RST;
      run_q <= RUN_RST;
    end else if (clk_en && acc_wr) begin
      if (hit_cfg) cfg_q <= wr16;
      if (hit_lhi) lvl_hi_q <= wr16;
      if (hit_llo) level_q <= {lvl_hi_q, wr16};
      if (hit_period) period_q <= wr16;
      if (hit_delay) delay_q <= wr16;
      if (hit_run) run_q <= wr16;
    end
  end

  // ---------------------------------------------------------------
  // Capture sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      per_cnt_q <= 16'h0000;
      wr_ptr_q <= '0;
      start_q <= '0;
      pre_have_q <= '0;
      count_q <= 16'h0000;
      post_wait_q <= 16'h0000;
    end else if (clk_en) begin
      if (ref_tick) per_cnt_q <= sample_en ? 16'h0000 : per_next;
      if (mem_wr) wr_ptr_q <= wr_ptr_inc;
      if (restart) begin
        state_q <= ST_ARMED;
        per_cnt_q <= 16'h0000;
        wr_ptr_q <= '0;
        start_q <= '0;
        pre_have_q <= '0;
        count_q <= 16'h0000;
        post_wait_q <= 16'h0000;
      end else if (stop) begin
        if (state_q != ST_IDLE) state_q <= ST_DONE;
      end else begin
        case (state_q)
          ST_IDLE: state_q <= ST_IDLE;
          ST_ARMED: begin
            if (pre_wr && !fire && (pre_have_q < pre_lim)) pre_have_q <= pre_have_q + 1'b1;
            if (fire && single_mode) begin
              count_q <= count_q + 16'h0001;
              if (buf_full_next) state_q <= ST_DONE;
            end else if (fire) begin
              state_q <= ST_COLLECT;
              if (delay_neg) begin
                start_q <= wr_ptr_q - pre_have_q;
                count_q <= {3'b000, pre_have_q} + 16'h0001;
              end else begin
                start_q <= wr_ptr_q;
                count_q <= (delay_q == 16'h0000) ? 16'h0001 : 16'h0000;
                post_wait_q <= (delay_q == 16'h0000) ? 16'h0000 : delay_q - 16'h0001;
              end
            end
          end
          ST_COLLECT: begin
            if (sample_en && (post_wait_q != 16'h0000)) post_wait_q <= post_wait_q - 16'h0001;
            if (coll_wr) begin
              count_q <= count_q + 16'h0001;
              if (buf_full_next) state_q <= ST_DONE;
            end
          end
          ST_DONE: state_q <= ST_DONE;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Readout prefetch into the pair buffer
  // ---------------------------------------------------------------
  wire enter_done = (state_q != ST_DONE) && !restart &&
                    (stop ? (state_q != ST_IDLE) :
                     ((fire && single_mode && buf_full_next) || (coll_wr && buf_full_next)));
  wire [15:0] final_count = stop ? count_q : count_q + 16'h0001;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q <= '0;
      rd_left_q <= 16'h0000;
      pend_q <= 1'b0;
    end else if (clk_en) begin
      if (restart) begin
        rd_left_q <= 16'h0000;
        pend_q <= 1'b0;
      end else if (enter_done) begin
        rd_ptr_q <= start_q;
        rd_left_q <= final_count;
      end else if (rd_issue) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        rd_left_q <= rd_left_q - 16'h0001;
        pend_q <= 1'b1;
      end else if (rd_in.ready) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Answers and registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 32'h0000_0000;
      rsp_err_q <= 1'b0;
      capture_clr_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (accept) begin
        rsp_valid_q <= 1'b1;
        rsp_data_q <= obj_wr ? 32'h0000_0000 : rd_mux;
        rsp_err_q <= obj_wr ? wr_err : rd_err;
      end else if (rsp_ready) begin
        rsp_valid_q <= 1'b0;
      end
      capture_clr_q <= (fire && (trig_type == TRG_CAPT)) ? level_q : 32'h0000_0000;
    end
  end

  // Channel select and state flags are registered copies so every output leaves a flop.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_chan <= 4'h0;
      trace_busy <= 1'b0;
      trace_done <= 1'b0;
    end else if (clk_en) begin
      trig_chan <= cfg_q[CH_LSB +: CH_W];
      trace_busy <= (state_q == ST_ARMED) || (state_q == ST_COLLECT);
      trace_done <= (state_q == ST_DONE);
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_err = rsp_err_q;
  assign capture_clr = capture_clr_q;
endmodule : trace_capture

// ---- verif/trace_capture_assertions.sv ----
`timescale 1ns/1ps
module trace_capture_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic obj_req,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  input wire logic [31:0] obj_wdata,
  input wire logic rsp_ready,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_err,
  input wire logic [3:0] trig_chan,
  input wire logic trace_busy,
  input wire logic trace_done
);
  import trace_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // A request only counts while the answer slot is free.
  // ----------------------------------------
  wire logic take = clk_en && obj_req && !rsp_valid;
  sequence s_wr(logic [15:0] idx);
    take && obj_wr && obj_index == idx;
  endsequence
  sequence s_run(logic stop);
    s_wr(IDX_RUN) ##0 ((obj_wdata[15:0] == 16'h0) == stop);
  endsequence
  property p_answer;
    take |=> rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_hold;
    rsp_valid && !(clk_en && rsp_ready) |=> rsp_valid && $stable(rsp_data) && $stable(rsp_err);
  endproperty
  a_hold: assert property (p_hold) else $error("answer changed before it was taken");
  property p_release;
    rsp_valid && clk_en && rsp_ready |=> !rsp_valid;
  endproperty
  a_release: assert property (p_release) else $error("answer kept after it was taken");
  property p_ro_data;
    s_wr(IDX_DATA) |=> rsp_err;
  endproperty
  a_ro_data: assert property (p_ro_data) else $error("write to sample data accepted");
  property p_ro_count;
    s_wr(IDX_SAMPLE_COUNT) |=> rsp_err;
  endproperty
  a_ro_count: assert property (p_ro_count) else $error("write to sample count accepted");
  property p_cfg_chan;
    logic [3:0] ch;
    (take && obj_wr && obj_index == IDX_TRIG_CFG && obj_sub == SUB_CFG, ch = obj_wdata[3:0]) |-> ##2 trig_chan == ch;
  endproperty
  a_cfg_chan: assert property (p_cfg_chan) else $error("trigger channel not taken from bits 3:0");
  property p_stop;
    s_run(1'b1) |-> ##[1:3] !trace_busy;
  endproperty
  a_stop: assert property (p_stop) else $error("capture still busy after stop");
  property p_restart;
    s_run(1'b0) |-> ##[1:3] trace_busy && !trace_done;
  endproperty
  a_restart: assert property (p_restart) else $error("capture not rearmed after restart");
endmodule : trace_capture_assertions

bind trace_capture trace_capture_assertions u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .obj_req(obj_req), .obj_wr(obj_wr),
  .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata), .rsp_ready(rsp_ready),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .trig_chan(trig_chan),
  .trace_busy(trace_busy), .trace_done(trace_done)
);

// ---- verif/obj_host.sv ----
`timescale 1ns/1ps
module obj_host (
  input wire logic sys_clk,
  input wire logic stall,
  output logic obj_req,
  output logic obj_wr,
  output logic [15:0] obj_index,
  output logic [7:0] obj_sub,
  output logic [31:0] obj_wdata,
  output logic rsp_ready,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_err
);
  initial begin
    obj_req = 1'b0;
    obj_wr = 1'b0;
    obj_index = 16'h0;
    obj_sub = 8'h0;
    obj_wdata = 32'h0;
    rsp_ready = 1'b0;
  end
  // ----------------------------------------
  // One access. Released lines show inverted data so stale values never look valid.
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    obj_req = 1'b1;
    obj_wr = wr;
    obj_index = idx;
    obj_sub = sub;
    obj_wdata = wd;
    rsp_ready = !stall;
    @(posedge sys_clk);
    #1;
    obj_req = 1'b0;
    obj_wdata = ~wd;
    obj_sub = ~sub;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20);
    if (!rsp_ready) begin
      #1;
      rsp_ready = 1'b1;
      @(posedge sys_clk);
    end
    rd = (n < 20) ? rsp_data : 32'hX;
    er = (n < 20) ? rsp_err : 1'bX;
    #1;
    rsp_ready = !stall;
  endtask : xfer
endmodule : obj_host

// ---- verif/trace_capture_tb_top.sv ----
`timescale 1ns/1ps
module trace_capture_tb_top;
  import trace_pkg::*;
  logic sys_clk, rst_n, clk_en, ref_tick, fgen_start, fgen_active, stall, er;
  logic [31:0] sample_word, val, clr_seen, rd;
  wire logic obj_req, obj_wr, rsp_ready, rsp_valid, rsp_err, trace_busy, trace_done;
  wire logic [15:0] obj_index;
  wire logic [7:0] obj_sub;
  wire logic [31:0] obj_wdata, rsp_data, capture_clr;
  wire logic [3:0] trig_chan;
  int err_total, num_checks, cyc;
  // Per trigger type: two arming samples that must not fire, then the firing value.
  logic [35:0] tv [1:11] = '{36'h0FF0FF100, 36'h101101100, 36'h200050200, 36'h050200050, 36'hEFFEFF100,
    36'h1FF1FF0FF, 36'h123123124, 36'h100000100, 36'h000100000, 36'h000000000, 36'h000000100};

  obj_host u_host (.sys_clk(sys_clk), .stall(stall), .obj_req(obj_req), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_sub(obj_sub), .obj_wdata(obj_wdata), .rsp_ready(rsp_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err));
  trace_capture u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .obj_req(obj_req), .obj_wr(obj_wr),
    .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata), .rsp_ready(rsp_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .ref_tick(ref_tick),
    .sample_word(sample_word), .trig_chan_value(val), .event_status(val), .capture_status(val),
    .fgen_start(fgen_start), .fgen_active(fgen_active), .trig_chan(trig_chan),
    .capture_clr(capture_clr), .trace_busy(trace_busy), .trace_done(trace_done)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (capture_clr !== 32'h0) clr_seen <= capture_clr;
    if (cyc > 5000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    u_host.xfer(1'b1, idx, sub, d, rd, er);
    chk({31'h0, er}, 32'h0);
  endtask : wr
  task automatic chk_rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    u_host.xfer(1'b0, idx, sub, 32'h0, rd, er);
    chk({31'h0, er}, 32'h0);
    chk(rd, exp);
  endtask : chk_rd
  task automatic chk_err(input logic w, input logic [15:0] idx);
    u_host.xfer(w, idx, 8'h00, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
  endtask : chk_err
  // ----------------------------------------
  // One sample: new channel value and a fresh sample word with a reference tick.
  // ----------------------------------------
  task automatic tick(input logic [31:0] v);
    @(posedge sys_clk);
    #1;
    val = v;
    sample_word = sample_word + 32'h1;
    ref_tick = 1'b1;
    @(posedge sys_clk);
    #1;
    ref_tick = 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : tick
  task automatic run_case(input logic [15:0] dly, input int npre, input int npost, input int nexp);
    wr(IDX_DELAY, 8'h00, {16'h0, dly});
    wr(IDX_RUN, 8'h00, 32'h1);
    repeat (npre) tick(32'h5);
    repeat (npost + 1) tick(32'h6);
    wr(IDX_RUN, 8'h00, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, trace_done}, 32'h1);
    for (int i = nexp - 1; i >= 0; i--) chk_rd(IDX_DATA, 8'h00, sample_word - 32'(i));
    chk_err(1'b0, IDX_DATA);
  endtask : run_case

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    ref_tick = 1'b0;
    fgen_start = 1'b0;
    fgen_active = 1'b1;
    stall = 1'b1;
    sample_word = 32'h0;
    val = 32'h0;
    clr_seen = 32'h0;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk_rd(IDX_PERIOD, 8'h00, 32'h1);
    chk_rd(IDX_DELAY, 8'h00, 32'h0);
    chk_rd(IDX_RUN, 8'h00, 32'h0);
    chk_rd(IDX_MAX_SAMPLES, 8'h00, 32'h2000);
    stall = 1'b0;
    chk_err(1'b0, IDX_DATA);
    chk_err(1'b1, IDX_DATA);
    chk_err(1'b1, IDX_SAMPLE_COUNT);
    chk_err(1'b0, 16'h2600);
    wr(IDX_TRIG_CFG, SUB_LVL_HI, 32'h1234);
    wr(IDX_TRIG_CFG, SUB_LVL_LO, 32'h5678);
    chk_rd(IDX_TRIG_CFG, SUB_LVL_HI, 32'h1234);
    chk_rd(IDX_TRIG_CFG, SUB_LVL_LO, 32'h5678);
    wr(IDX_TRIG_CFG, SUB_LVL_HI, 32'h0);
    wr(IDX_TRIG_CFG, SUB_LVL_LO, 32'h100);
    for (int t = 1; t < 12; t++) begin
      wr(IDX_TRIG_CFG, SUB_CFG, {20'h0, 4'(t), 4'h0, 4'(t)});
      chk({28'h0, trig_chan}, 32'(t));
      wr(IDX_RUN, 8'h00, 32'h1);
      tick({20'h0, tv[t][35:24]});
      tick({20'h0, tv[t][23:12]});
      chk_rd(IDX_SAMPLE_COUNT, 8'h00, 32'h0);
      @(posedge sys_clk);
      #1;
      fgen_start = 1'b1;
      @(posedge sys_clk);
      #1;
      fgen_start = 1'b0;
      tick({20'h0, tv[t][11:0]});
      tick({20'h0, tv[t][11:0]});
      chk_rd(IDX_SAMPLE_COUNT, 8'h00, 32'h2);
    end
    chk(clr_seen, 32'h100);
    wr(IDX_TRIG_CFG, SUB_CFG, 32'h0700);
    run_case(16'h0000, 2, 1, 2);
    run_case(16'h0002, 2, 3, 2);
    run_case(16'hFFFE, 4, 0, 3);
    run_case(16'hFF9C, 2, 0, 3);
    wr(IDX_TRIG_CFG, SUB_CFG, 32'h8700);
    wr(IDX_RUN, 8'h00, 32'h1);
    for (int i = 0; i < 6; i++) tick(32'(5 + i / 2));
    chk_rd(IDX_SAMPLE_COUNT, 8'h00, 32'h2);
    wr(IDX_PERIOD, 8'h00, 32'h2);
    wr(IDX_RUN, 8'h00, 32'h1);
    for (int i = 1; i < 5; i++) tick(32'(i));
    chk_rd(IDX_SAMPLE_COUNT, 8'h00, 32'h1);
    clk_en = 1'b0;
    tick(32'h5);
    tick(32'h6);
    #1;
    clk_en = 1'b1;
    chk_rd(IDX_SAMPLE_COUNT, 8'h00, 32'h1);
    print_verdict();
  end
endmodule : trace_capture_tb_top
